// file: logic/meas_ctrl_pkg.sv
package meas_ctrl_pkg;

    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] CNT_OFS = 8'h0C;
    localparam logic [7:0] EVT_OFS = 8'h10;
    localparam logic [7:0] QLIST_OFS = 8'h14;
    localparam logic [7:0] QITEM_OFS = 8'h18;
    localparam logic [7:0] ERR_OFS = 8'h1C;

    // ==========================================================
    // configuration field positions
    localparam int REP_LSB = 0;
    localparam int STEP_BIT = 2;
    localparam int EREP_LSB = 3;
    localparam int PUSE_BIT = 5;
    localparam int STOPCNT_LSB = 8;
    localparam int PPC_LSB = 22;
    localparam logic [31:0] CFG_RESET = 32'h0040_0004;

    // event and counter field positions
    localparam int OPC_BIT = 0;
    localparam int SRQ_BIT = 6;
    localparam int CYC_NONE_BIT = 15;
    localparam int PER_LSB = 16;
    localparam int PER_NONE_BIT = 31;
    localparam int BUSY_BIT = 4;
    localparam logic [13:0] CYCLE_MAX = 14'h2710;

    // error codes as 16-bit two's complement
    localparam logic [15:0] ERR_INIT_IGNORED = 16'hFF2B;
    localparam logic [15:0] ERR_SETTINGS = 16'hFF23;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        CMD_START = 3'h1,
        CMD_CANCEL = 3'h2,
        CMD_HALT = 3'h3,
        CMD_RESUME = 3'h4,
        CMD_OPC = 3'h5
    } cmd_e;

    typedef enum logic [1:0] {
        ST_OFF = 2'h0,
        ST_RUN = 2'h1,
        ST_STOPPED = 2'h2,
        ST_STEPPED = 2'h3
    } meas_state_e;

    typedef enum logic [2:0] {
        SC_OFF = 3'h0,
        SC_RUN = 3'h1,
        SC_STOP = 3'h2,
        SC_STEP = 3'h3,
        SC_FINISHED = 3'h4,
        SC_START_FAILED = 3'h5
    } status_code_e;

    typedef enum logic [1:0] {
        REP_SINGLE = 2'h0,
        REP_CONT = 2'h1,
        REP_COUNT = 2'h2
    } rep_mode_e;

    typedef enum logic [1:0] {
        EREP_OFF = 2'h0,
        EREP_SRQ = 2'h1,
        EREP_SINGLE_OP_COMPLETE_MODE = 2'h2,
        EREP_REQUEST_AND_COMPLETE_MODE = 2'h3
    } erep_e;

endpackage : meas_ctrl_pkg

// file: logic/measurement_state_control.sv
// Functional notes
// [RULE1] four states: off, running, stopped, stepped
// [RULE2] start zeroes counters, invalidates values
// [RULE3] start accepted anywhere, restarts if running
// [RULE4] start reserves; conflict: off, failed, -213
// [RULE5] conflict when rf connector held elsewhere
// [RULE6] start overlapped; opc sets bit0 immediately
// [RULE7] cancel: off at once, invalidate, release
// [RULE8] halt stops at period end, keeps results
// [RULE9] halt only from running/stepped, else -221
// [RULE10] halt-reached stop raises no report
// [RULE11] resume from stopped/stepped, back to running
// [RULE12] resume after finish restarts, zeroes counters
// [RULE13] resume elsewhere: -221, state unchanged
// [RULE14] step mode pauses each period, reports
// [RULE15] single shot stops after one period
// [RULE16] report sets srq bit6 and/or opc bit0
// [RULE17] report adds ready queue entry unless off
// [RULE18] list read clears all, item clears one
// [RULE19] status: code, cycle count, period count
// [RULE20] finished when stopped by its own conditions
// [RULE21] cycle count 0..10000 counting mode, else none
// [RULE22] period count, or none when unused
// [RULE23] every error pushes one error queue entry; here a full queue drops the new entry
// [RULE24] commands in order; halt holds off later
//
// The register addresses and the APB interface to the registers are this design's own decisions.
module measurement_state_control #(
    parameter int ERRQ_DEPTH = 4,
    parameter int ERRQ_AW = 2
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rf_held_other_i,
    input wire logic period_done_i,
    output logic rf_reserve_o,
    output logic measure_run_o,
    output logic invalidate_o,
    output logic opc_bit_o,
    output logic srq_bit_o
);

    // ==========================================================
    // reset release and input synchroniser
    logic rst_meta_r;
    logic rst_n_r;
    logic rf_meta_r;
    logic rf_busy_r;

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rf_meta_r <= 1'b0;
            rf_busy_r <= 1'b0;
        end
        else
        begin
            rf_meta_r <= rf_held_other_i;
            rf_busy_r <= rf_meta_r;
        end
    end

    // ==========================================================
    // state and configuration
    meas_ctrl_pkg::meas_state_e state_r;
    logic finished_r;
    logic failed_r;
    logic halt_pending_r;
    logic [31:0] cfg_r;
    logic [13:0] cycle_cnt_r;
    logic [15:0] period_cnt_r;
    logic opc_r;
    logic srq_r;
    logic ready_r;
    logic invalidate_r;
    logic [31:0] prdata_r;

    logic [1:0] rep_mode;
    logic step_sel;
    logic [1:0] erep;
    logic [13:0] stop_cnt;
    logic [9:0] per_per_cycle;

    assign rep_mode = cfg_r[meas_ctrl_pkg::REP_LSB +: 2];
    assign step_sel = cfg_r[meas_ctrl_pkg::STEP_BIT];
    assign erep = cfg_r[meas_ctrl_pkg::EREP_LSB +: 2];
    assign stop_cnt = cfg_r[meas_ctrl_pkg::STOPCNT_LSB +: 14];
    assign per_per_cycle = cfg_r[meas_ctrl_pkg::PPC_LSB +: 10];

    // ==========================================================
    // bus decode
    logic access;
    logic cmd_wr;
    logic cmd_fire;
    logic [2:0] cmd_code;
    logic mapped;
    logic rd_done;

    assign access = psel_i && penable_i;
    assign cmd_wr = pwrite_i && (paddr_i == meas_ctrl_pkg::CMD_OFS);
    // a pending halt stalls the next command until stopped is reached
    assign pready_o = !(cmd_wr && halt_pending_r); // RULE24
    assign cmd_fire = access && cmd_wr && pready_o;
    assign cmd_code = pwdata_i[2:0];
    assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= meas_ctrl_pkg::ERR_OFS);
    assign pslverr_o = access && !mapped;
    assign rd_done = access && !pwrite_i && mapped;
    assign prdata_o = prdata_r;

    // ==========================================================
    // measurement events
    logic period_evt;
    logic cycle_end;
    logic finish_now;
    logic step_now;
    logic report_evt;
    logic err_evt;
    logic [15:0] err_code;

    assign period_evt = period_done_i && (state_r == meas_ctrl_pkg::ST_RUN);
    assign cycle_end = period_evt && ((period_cnt_r + 16'h0001) >= {6'h00, per_per_cycle});
    assign finish_now = period_evt && ((rep_mode == meas_ctrl_pkg::REP_SINGLE) // RULE15
        || ((rep_mode == meas_ctrl_pkg::REP_COUNT) && cycle_end
        && ((cycle_cnt_r + 14'h0001) >= stop_cnt)));
    assign step_now = period_evt && step_sel && (rep_mode != meas_ctrl_pkg::REP_SINGLE); // RULE14
    // a halt-ended period never reports
    assign report_evt = !cmd_fire && !halt_pending_r && (finish_now || step_now); // RULE10

    always_comb
    begin
        err_evt = 1'b0;
        err_code = meas_ctrl_pkg::ERR_SETTINGS;
        if (cmd_fire)
        begin
            case (cmd_code)
                meas_ctrl_pkg::CMD_START:
                begin
                    err_evt = rf_busy_r; // RULE4 RULE5
                    err_code = meas_ctrl_pkg::ERR_INIT_IGNORED;
                end
                meas_ctrl_pkg::CMD_HALT:
                    err_evt = (state_r == meas_ctrl_pkg::ST_OFF)
                        || (state_r == meas_ctrl_pkg::ST_STOPPED); // RULE9
                meas_ctrl_pkg::CMD_RESUME:
                    err_evt = (state_r == meas_ctrl_pkg::ST_OFF)
                        || (state_r == meas_ctrl_pkg::ST_RUN); // RULE13
                default:
                    err_evt = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // measurement state machine
    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r <= meas_ctrl_pkg::ST_OFF;
            finished_r <= 1'b0;
            failed_r <= 1'b0;
            halt_pending_r <= 1'b0;
        end
        else if (cmd_fire)
        begin
            case (cmd_code)
                meas_ctrl_pkg::CMD_START:
                begin
                    // a running measurement is dropped and restarted in one step
                    state_r <= rf_busy_r ? meas_ctrl_pkg::ST_OFF
                        : meas_ctrl_pkg::ST_RUN; // RULE3 RULE4 RULE5
                    failed_r <= rf_busy_r; // RULE4
                    finished_r <= 1'b0;
                    halt_pending_r <= 1'b0;
                end
                meas_ctrl_pkg::CMD_CANCEL:
                begin
                    state_r <= meas_ctrl_pkg::ST_OFF; // RULE7
                    finished_r <= 1'b0;
                    failed_r <= 1'b0;
                    halt_pending_r <= 1'b0;
                end
                meas_ctrl_pkg::CMD_HALT:
                begin
                    if (state_r == meas_ctrl_pkg::ST_RUN)
                    begin
                        halt_pending_r <= 1'b1; // RULE8
                    end
                    else if (state_r == meas_ctrl_pkg::ST_STEPPED)
                    begin
                        state_r <= meas_ctrl_pkg::ST_STOPPED; // RULE8
                    end
                end
                meas_ctrl_pkg::CMD_RESUME:
                begin
                    if ((state_r == meas_ctrl_pkg::ST_STOPPED)
                        || (state_r == meas_ctrl_pkg::ST_STEPPED))
                    begin
                        state_r <= meas_ctrl_pkg::ST_RUN; // RULE11
                        finished_r <= 1'b0;
                    end
                end
                default:
                begin
                    state_r <= state_r;
                end
            endcase
        end
        else if (period_evt)
        begin
            if (halt_pending_r)
            begin
                state_r <= meas_ctrl_pkg::ST_STOPPED; // RULE8
                halt_pending_r <= 1'b0;
            end
            else if (finish_now)
            begin
                state_r <= meas_ctrl_pkg::ST_STOPPED; // RULE20
                finished_r <= 1'b1;
            end
            else if (step_now)
            begin
                state_r <= meas_ctrl_pkg::ST_STEPPED; // RULE14 RULE1
            end
        end
    end

    // ==========================================================
    // evaluation period and statistics cycle counters
    logic zero_cnt;

    assign zero_cnt = cmd_fire && ((cmd_code == meas_ctrl_pkg::CMD_START) // RULE2
        || ((cmd_code == meas_ctrl_pkg::CMD_RESUME) && finished_r
        && (state_r == meas_ctrl_pkg::ST_STOPPED))); // RULE12

    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            period_cnt_r <= 16'h0000;
            cycle_cnt_r <= 14'h0000;
        end
        else if (zero_cnt)
        begin
            period_cnt_r <= 16'h0000;
            cycle_cnt_r <= 14'h0000;
        end
        else if (period_evt && !cmd_fire)
        begin
            if (cycle_end)
            begin
                period_cnt_r <= 16'h0000;
                if (cycle_cnt_r < meas_ctrl_pkg::CYCLE_MAX)
                begin
                    cycle_cnt_r <= cycle_cnt_r + 14'h0001; // RULE21
                end
            end
            else
            begin
                period_cnt_r <= period_cnt_r + 16'h0001; // RULE22
            end
        end
    end

    // ==========================================================
    // configuration, invalidate pulse, event bits
    logic evt_clr;

    assign evt_clr = access && pwrite_i && (paddr_i == meas_ctrl_pkg::EVT_OFS);

    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            cfg_r <= meas_ctrl_pkg::CFG_RESET;
        end
        else if (access && pwrite_i && (paddr_i == meas_ctrl_pkg::CFG_OFS))
        begin
            cfg_r <= pwdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            invalidate_r <= 1'b0;
        end
        else
        begin
            invalidate_r <= cmd_fire && ((cmd_code == meas_ctrl_pkg::CMD_START)
                || (cmd_code == meas_ctrl_pkg::CMD_CANCEL)); // RULE2 RULE7
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            opc_r <= 1'b0;
            srq_r <= 1'b0;
        end
        else
        begin
            if ((report_evt && erep[1]) || (cmd_fire && (cmd_code == meas_ctrl_pkg::CMD_OPC)))
            begin
                opc_r <= 1'b1; // RULE16 RULE6
            end
            else if (evt_clr && pwdata_i[meas_ctrl_pkg::OPC_BIT])
            begin
                opc_r <= 1'b0;
            end
            if (report_evt && erep[0])
            begin
                srq_r <= 1'b1; // RULE16
            end
            else if (evt_clr && pwdata_i[meas_ctrl_pkg::SRQ_BIT])
            begin
                srq_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // ready queue: one entry for this measurement
    logic q_rd;

    // only an entry that was returned to the host is cleared
    assign q_rd = rd_done && ((paddr_i == meas_ctrl_pkg::QLIST_OFS)
        || (paddr_i == meas_ctrl_pkg::QITEM_OFS)) && prdata_r[0];

    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ready_r <= 1'b0;
        end
        else if (report_evt && (erep != meas_ctrl_pkg::EREP_OFF))
        begin
            ready_r <= 1'b1; // RULE17
        end
        else if (q_rd)
        begin
            ready_r <= 1'b0; // RULE18
        end
    end

    // ==========================================================
    // error queue; a full queue drops new entries
    logic [15:0] errq_mem [ERRQ_DEPTH];
    logic [ERRQ_AW:0] errq_wp_r;
    logic [ERRQ_AW:0] errq_rp_r;
    logic errq_empty;
    logic errq_full;
    logic errq_pop;

    assign errq_empty = (errq_wp_r == errq_rp_r);
    assign errq_full = (errq_wp_r[ERRQ_AW-1:0] == errq_rp_r[ERRQ_AW-1:0]) && !errq_empty;
    assign errq_pop = rd_done && (paddr_i == meas_ctrl_pkg::ERR_OFS) && !errq_empty;

    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            errq_wp_r <= '0;
            errq_rp_r <= '0;
        end
        else
        begin
            if (err_evt && !errq_full)
            begin
                errq_wp_r <= errq_wp_r + 1'b1; // RULE23
            end
            if (errq_pop)
            begin
                errq_rp_r <= errq_rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (err_evt && !errq_full)
        begin
            errq_mem[errq_wp_r[ERRQ_AW-1:0]] <= err_code; // RULE23
        end
    end

    // ==========================================================
    // read data, latched in the setup cycle
    logic [2:0] status_code;

    always_comb
    begin
        case (state_r)
            meas_ctrl_pkg::ST_OFF:
                status_code = failed_r ? meas_ctrl_pkg::SC_START_FAILED
                    : meas_ctrl_pkg::SC_OFF; // RULE19
            meas_ctrl_pkg::ST_RUN:
                status_code = meas_ctrl_pkg::SC_RUN;
            meas_ctrl_pkg::ST_STOPPED:
                status_code = finished_r ? meas_ctrl_pkg::SC_FINISHED
                    : meas_ctrl_pkg::SC_STOP; // RULE20
            meas_ctrl_pkg::ST_STEPPED:
                status_code = meas_ctrl_pkg::SC_STEP;
            default:
                status_code = meas_ctrl_pkg::SC_OFF;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else if (psel_i && !penable_i)
        begin
            prdata_r <= 32'h0000_0000;
            case (paddr_i)
                meas_ctrl_pkg::CFG_OFS:
                    prdata_r <= cfg_r;
                meas_ctrl_pkg::STAT_OFS:
                begin
                    prdata_r[2:0] <= status_code; // RULE19
                    prdata_r[meas_ctrl_pkg::BUSY_BIT] <= halt_pending_r;
                end
                meas_ctrl_pkg::CNT_OFS:
                begin
                    prdata_r[13:0] <= cycle_cnt_r;
                    prdata_r[meas_ctrl_pkg::CYC_NONE_BIT] <=
                        (rep_mode != meas_ctrl_pkg::REP_COUNT); // RULE21
                    prdata_r[meas_ctrl_pkg::PER_LSB +: 15] <= period_cnt_r[14:0];
                    prdata_r[meas_ctrl_pkg::PER_NONE_BIT] <=
                        !cfg_r[meas_ctrl_pkg::PUSE_BIT]; // RULE22
                end
                meas_ctrl_pkg::EVT_OFS:
                begin
                    prdata_r[meas_ctrl_pkg::OPC_BIT] <= opc_r;
                    prdata_r[meas_ctrl_pkg::SRQ_BIT] <= srq_r;
                end
                meas_ctrl_pkg::QLIST_OFS,
                meas_ctrl_pkg::QITEM_OFS:
                    prdata_r[0] <= ready_r; // RULE18
                meas_ctrl_pkg::ERR_OFS:
                    prdata_r[15:0] <= errq_empty ? 16'h0000
                        : errq_mem[errq_rp_r[ERRQ_AW-1:0]];
                default:
                    prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign rf_reserve_o = (state_r != meas_ctrl_pkg::ST_OFF); // RULE7 RULE8
    assign measure_run_o = (state_r == meas_ctrl_pkg::ST_RUN);
    assign invalidate_o = invalidate_r;
    assign opc_bit_o = opc_r;
    assign srq_bit_o = srq_r;

    // ==========================================================
    // checks
    a_start_conflict_off: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE4
        cmd_fire && cmd_code == meas_ctrl_pkg::CMD_START && rf_busy_r
        |=> state_r == meas_ctrl_pkg::ST_OFF && status_code == meas_ctrl_pkg::SC_START_FAILED)
        else $error("start under conflict did not fail");
    a_start_zeroes: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE2
        cmd_fire && cmd_code == meas_ctrl_pkg::CMD_START && !rf_busy_r
        |=> measure_run_o && period_cnt_r == 16'h0000 && cycle_cnt_r == 14'h0000 && invalidate_o)
        else $error("start did not run with cleared counters");
    a_cancel_to_off: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE7
        cmd_fire && cmd_code == meas_ctrl_pkg::CMD_CANCEL |=> !rf_reserve_o ##1 !invalidate_o)
        else $error("cancel did not release");
    a_halt_off_err: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE9
        cmd_fire && cmd_code == meas_ctrl_pkg::CMD_HALT && state_r == meas_ctrl_pkg::ST_OFF
        |-> err_evt && err_code == meas_ctrl_pkg::ERR_SETTINGS)
        else $error("halt while off raised no error");
    a_resume_bad_keep: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE13
        cmd_fire && cmd_code == meas_ctrl_pkg::CMD_RESUME && state_r == meas_ctrl_pkg::ST_OFF
        |=> state_r == meas_ctrl_pkg::ST_OFF)
        else $error("bad resume changed state");
    a_halt_no_report: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE10
        halt_pending_r && period_evt && !cmd_fire
        |-> !report_evt ##1 (state_r == meas_ctrl_pkg::ST_STOPPED && !finished_r))
        else $error("halt stop reported or missed");
    a_single_finish: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE15
        period_evt && !cmd_fire && !halt_pending_r && rep_mode == meas_ctrl_pkg::REP_SINGLE
        |=> status_code == meas_ctrl_pkg::SC_FINISHED)
        else $error("single shot did not finish");
    a_report_srq: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE16
        report_evt && erep == meas_ctrl_pkg::EREP_REQUEST_AND_COMPLETE_MODE |=> srq_bit_o && opc_bit_o && ready_r)
        else $error("report bits not set");
    a_halt_holdoff: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE24
        halt_pending_r && access && cmd_wr |-> !pready_o && measure_run_o)
        else $error("command taken during pending halt");

endmodule : measurement_state_control

// file: dv/meas_far_side.sv
// ==========================================
// far side: rf connector owner and period source
module meas_far_side (
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic run_i,
    input wire logic busy_i,
    output logic period_done_o,
    output logic rf_held_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap = 3;
    // other measurement or generator holding the connector
    assign rf_held_o = busy_i;
    // random spacing so period ends do not line up with bus cycles
    always @(posedge clock_i)
    begin
        period_done_o <= 1'b0;
        if (go_i && run_i)
        begin
            if (gap == 0)
            begin
                period_done_o <= 1'b1;
                gap = 2 + ($urandom % 4);
            end
            else
                gap--;
        end
    end
endmodule : meas_far_side

// file: dv/measurement_state_control_bench.sv
// ==========================================
// bench top
module measurement_state_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, reset_n_i, psel, penable, pwrite, pready, pslverr, er, go, busy;
    logic pd, rf, reserve, run, inval, opc, srq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_mismatch = 0;
    int check_count = 0;
    int ms = 0;
    int errq[$];
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    measurement_state_control dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .rf_held_other_i(rf), .period_done_i(pd), .rf_reserve_o(reserve),
        .measure_run_o(run), .invalidate_o(inval), .opc_bit_o(opc), .srq_bit_o(srq));
    meas_far_side far_u (.clock_i(clock_i), .go_i(go), .run_i(run), .busy_i(busy),
        .period_done_o(pd), .rf_held_o(rf));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock_i);
    endtask : apb
    // command plus the reference state machine
    task cmd(input int c);
        case (c)
            1: if (busy) begin ms = 5; errq.push_back(-213); end else ms = 1;
            2: ms = 0;
            3: if (ms == 1 || ms == 3) ms = 2; else errq.push_back(-221);
            4: if (ms inside {2, 3, 4}) ms = 1; else errq.push_back(-221);
            default: ;
        endcase
        apb(1'b1, meas_ctrl_pkg::CMD_OFS, 32'(c));
    endtask : cmd
    task stat();
        apb(1'b0, meas_ctrl_pkg::STAT_OFS, 32'h0);
        chk("status", 32'(ms), 32'(rd[2:0]));
    endtask : stat
    task err_rd();
        apb(1'b0, meas_ctrl_pkg::ERR_OFS, 32'h0);
        chk("error", (errq.size() > 0) ? {16'h0000, 16'(errq.pop_front())} : 32'h0, rd);
    endtask : err_rd
    task q_rd(input logic [7:0] a, input logic e);
        apb(1'b0, a, 32'h0);
        chk("queue", 32'(e), 32'(rd[0]));
    endtask : q_rd
    task wait_end();
        @(posedge clock_i);
        go <= 1'b1;
        repeat (60) if (run === 1'b1) @(posedge clock_i);
        go <= 1'b0;
        @(negedge clock_i);
    endtask : wait_end
    task give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    initial
    begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        {reset_n_i, psel, penable, pwrite, go, busy, paddr, pwdata} = '0;
        void'($urandom(32'hF9E4874F));
        repeat (8) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        apb(1'b0, meas_ctrl_pkg::CFG_OFS, 32'h0);
        chk("cfg reset", 32'h0040_0004, rd);
        stat();
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
        cmd(3);
        cmd(4);
        stat();
        repeat (3) err_rd();
        $display("test reset and refusals done");
        @(posedge clock_i);
        busy <= 1'b1;
        repeat (4) @(posedge clock_i);
        cmd(1);
        stat();
        err_rd();
        @(posedge clock_i);
        busy <= 1'b0;
        repeat (4) @(posedge clock_i);
        $display("test conflict done");
        apb(1'b1, meas_ctrl_pkg::CFG_OFS, 32'h0040_0039);
        cmd(1);
        cmd(1);
        chk("inval run", 32'h3, {inval, run});
        stat();
        apb(1'b0, meas_ctrl_pkg::CNT_OFS, 32'h0);
        chk("counters", 32'h0000_8000, rd);
        cmd(5);
        chk("opc", 32'h1, 32'(opc));
        apb(1'b1, meas_ctrl_pkg::EVT_OFS, 32'h41);
        cmd(3);
        // the opc request stalls until the pending halt completes
        @(posedge clock_i);
        go <= 1'b1;
        cmd(5);
        @(posedge clock_i);
        go <= 1'b0;
        stat();
        chk("no report", 32'h2, {opc, srq});
        chk("held", 32'h1, 32'(reserve));
        q_rd(meas_ctrl_pkg::QLIST_OFS, 1'b0);
        $display("test start and halt done");
        apb(1'b1, meas_ctrl_pkg::CFG_OFS, 32'h0040_001C);
        cmd(4);
        stat();
        wait_end();
        ms = 4;
        stat();
        chk("report", 32'h3, {opc, srq});
        q_rd(meas_ctrl_pkg::QITEM_OFS, 1'b1);
        q_rd(meas_ctrl_pkg::QITEM_OFS, 1'b0);
        $display("test single shot done");
        apb(1'b1, meas_ctrl_pkg::EVT_OFS, 32'h41);
        apb(1'b1, meas_ctrl_pkg::CFG_OFS, 32'h0040_020E);
        cmd(4);
        apb(1'b0, meas_ctrl_pkg::CNT_OFS, 32'h0);
        chk("counters", 32'h8000_0000, rd);
        wait_end();
        ms = 3;
        stat();
        chk("report", 32'h1, {opc, srq});
        apb(1'b0, meas_ctrl_pkg::CNT_OFS, 32'h0);
        chk("cycle count", 32'h8000_0001, rd);
        q_rd(meas_ctrl_pkg::QLIST_OFS, 1'b1);
        q_rd(meas_ctrl_pkg::QLIST_OFS, 1'b0);
        cmd(3);
        stat();
        cmd(2);
        stat();
        chk("released", 32'h0, 32'(reserve));
        $display("test step and cancel done");
        give_verdict();
    end
endmodule : measurement_state_control_bench
